// >>> tmsl_pkg.sv
// Constants shared by the torque-mode speed limiter.
// Assumes one 25 MHz system clock and a control-cycle enable derived inside the block.
package tmsl_pkg;
    // ====================================================================
    // Clock and control cycle
    localparam int unsigned CLK_HZ             = 25000000;
    localparam int unsigned CTRL_CYCLE_US      = 100;
    localparam int unsigned CTRL_CYCLE_CLKS    = CLK_HZ / 1000000 * CTRL_CYCLE_US;
    // ====================================================================
    // Frequencies in 0.01 Hz units, 16 bits
    localparam int unsigned FREQ_W             = 16;
    localparam logic [15:0] ZERO_HZ            = 16'h0000;
    localparam logic [15:0] SETTING_UNUSED     = 16'h270F;  // 9999 selects the fallback
    localparam logic [15:0] FWD_LIMIT_RESET    = 16'h1770;  // 60 Hz
    // ====================================================================
    // Current loop gains
    localparam logic [15:0] PGAIN_DEFAULT_PCT  = 16'h0064;  // 100 %
    localparam logic [15:0] PGAIN_MAX_PCT      = 16'h01F4;  // 500 %
    localparam logic [15:0] ITIME_DEFAULT_MS   = 16'h0005;
    localparam logic [15:0] ITIME_MAX_MS       = 16'h01F4;
    localparam logic [15:0] PGAIN_RAD_SENSORLESS = 16'h03E8; // 1000 rad/s at 100 %
    localparam logic [15:0] PGAIN_RAD_ENCODER    = 16'h0578; // 1400 rad/s at 100 %
    localparam logic [15:0] PCT_FULL           = 16'h0064;
    // ====================================================================
    // Terminal function codes
    localparam logic [7:0]  OUT_FUNC_LIMIT_POS = 8'h03;
    localparam logic [7:0]  OUT_FUNC_LIMIT_NEG = 8'h67;     // 103
    localparam logic [7:0]  IN_FUNC_SECOND     = 8'h03;
    localparam logic [7:0]  DISPLAY_LIMIT_CODE = 8'hA1;
    localparam logic [7:0]  DISPLAY_NONE       = 8'h00;
    // ====================================================================
    // Register map (byte offsets, one word each)
    localparam logic [7:0] REG_CTRL       = 8'h00; // 0 source sel, 1 unused, 2 encoder mode
    localparam logic [7:0] REG_FWD_LIMIT  = 8'h04;
    localparam logic [7:0] REG_REV_LIMIT  = 8'h08;
    localparam logic [7:0] REG_MAX_FREQ   = 8'h0C;
    localparam logic [7:0] REG_MIN_FREQ   = 8'h10;
    localparam logic [7:0] REG_START_FREQ = 8'h14;
    localparam logic [7:0] REG_DCBRK_FREQ = 8'h18;
    localparam logic [7:0] REG_ACCEL_STEP = 8'h1C;
    localparam logic [7:0] REG_DECEL_STEP = 8'h20;
    localparam logic [7:0] REG_PGAIN1     = 8'h24;
    localparam logic [7:0] REG_ITIME1     = 8'h28;
    localparam logic [7:0] REG_PGAIN2     = 8'h2C;
    localparam logic [7:0] REG_ITIME2     = 8'h30;
    localparam logic [7:0] REG_FUNC_CODES = 8'h34; // [7:0] out code, [15:8] in code
    localparam logic [7:0] REG_STATUS     = 8'h38; // read clears
    localparam logic [7:0] REG_MASK       = 8'h3C;
    localparam logic [7:0] REG_LIMIT      = 8'h40; // effective limit, read only
    localparam logic [7:0] REG_GAINS      = 8'h44; // applied gain/time, read only
    localparam logic [15:0] MAX_FREQ_RESET  = 16'h1770;
    localparam logic [15:0] DCBRK_RESET     = 16'h012C;   // 3 Hz
    localparam logic [15:0] START_RESET     = 16'h0032;   // 0.5 Hz
    localparam logic [15:0] ACCEL_STEP_RESET = 16'h0001;
    localparam int unsigned EVT_W = 3; // 0 limit on, 1 limit off, 2 speed regulation entered

    typedef enum logic [1:0] {
        TMSL_IDLE  = 2'b00,
        TMSL_ACCEL = 2'b01,
        TMSL_HOLD  = 2'b11,
        TMSL_DECEL = 2'b10
    } tmsl_ramp_type;
endpackage

// >>> tmsl_limiter.sv
// Speed-limit generator and current-loop gain selector for torque control.
// Assumes synchronous inputs on sys_clk and a one-cycle-latency register port.
// How it works
// (R1) Command-path limit ramps from 0 Hz to set speed over accel time on run.
// (R2) On run drop the limit ramps down to DC-brake start frequency over decel time.
// (R3) Source select 0 uses the speed command path, 1 the stored forward limit.
// (R4) Load reversing against torque polarity switches to the reverse-side limit.
// (R5) A request above max frequency is replaced by max frequency.
// (R6) A request below min frequency is replaced by min frequency.
// (R7) A request below starting frequency forces the limit to 0 Hz.
// (R8) With source select 0 and no load reversing, any multispeed input asserted takes the limit from multispeed settings.
// (R9) Parameter mode limit sign follows torque sign; zero torque gives positive.
// (R10) Parameter mode forward and reverse limits are clamped to max frequency.
// (R11) While limiting, limit-active asserts and the display shows the limit code.
// (R12) Limit-active reaches the terminal only for function code 3 or 103.
// (R13) P gain spans 0 to 500 percent, default 100, scaled to rad/s by mode; only first-set writes are saturated, second-set writes are stored as written.
// (R14) Integral time spans 0 to 500 ms, default 5 ms; only first-set writes are saturated, second-set writes are stored as written.
// (R15) Second-function select picks second settings; 9999 falls back to first.
// (R16) Second-function select counts only on an input coded 3.
// (R17) Speed at or above the limit switches torque to speed regulation.
// (R18) Reverse-side setting 9999 reuses the forward limit.
// (R19) The ramp steps linearly once per control cycle by a set increment.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
module tmsl_limiter (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire logic        run_cmd,
    input  wire logic [15:0] speed_cmd,
    input  wire logic [15:0] multispeed_limit,
    input  wire logic        multispeed_high_in,
    input  wire logic        multispeed_mid_in,
    input  wire logic        multispeed_low_in,
    input  wire logic signed [15:0] torque_cmd,
    input  wire logic signed [15:0] actual_speed,
    input  wire logic        second_function_select,
    output logic signed [16:0] speed_limit,
    output logic             speed_reg_mode,
    output logic             limit_active_out,
    output logic [7:0]       limit_display_code,
    output logic [15:0]      current_p_gain,
    output logic [15:0]      current_p_gain_rad,
    output logic [15:0]      current_integral_time,
    output logic             irq
);
    // ====================================================================
    // State
    localparam int EVTW = tmsl_pkg::EVT_W;
    typedef struct packed {
        logic [31:0]  rdata;
        logic [2:0]   ctrl;
        logic [15:0]  fwd, rev, maxf, minf, startf, dcbrk, acc, dec;
        logic [15:0]  pg1, it1, pg2, it2;
        logic [15:0]  codes;
        logic [EVTW-1:0] stat, mask;
        logic [15:0]  cnt;
        tmsl_pkg::tmsl_ramp_type ramp;
        logic [15:0]  level;
        logic signed [16:0] limit;
        logic         active, spdreg, lout;
        logic [7:0]   disp;
        logic [15:0]  pg, pgrad, it;
        logic         irq;
    } tmsl_state_type;

    tmsl_state_type s_q, s_d;

    logic [15:0] request, clamped, rev_sel, target;
    logic        multispeed_any, reversing, second_on;
    logic        tick;
    logic signed [16:0] mag_s;
    logic [16:0] abs_speed;
    logic [31:0] rad_prod;

    always_comb begin
        s_d = s_q;
        tick = (s_q.cnt == 16'(tmsl_pkg::CTRL_CYCLE_CLKS - 1));
        s_d.cnt = tick ? 16'h0000 : s_q.cnt + 16'h0001;
        multispeed_any = multispeed_high_in | multispeed_mid_in | multispeed_low_in;
        // ================================================================
        // Request selection
        request = multispeed_any ? multispeed_limit : speed_cmd;  // R8
        abs_speed = actual_speed[15] ? 17'(-actual_speed) : 17'(actual_speed);
        // Load opposes torque when the speed sign differs from the torque sign
        reversing = (actual_speed != 16'sh0000)
                  && ((torque_cmd < 0) != (actual_speed < 0));  // R4
        rev_sel = (s_q.rev == tmsl_pkg::SETTING_UNUSED) ? s_q.fwd : s_q.rev;  // R18
        if (s_q.ctrl[0]) begin
            request = reversing ? rev_sel : s_q.fwd;  // R3 R4
            if (request > s_q.maxf) request = s_q.maxf;  // R10
        end else if (reversing) begin
            request = rev_sel;  // R4
        end
        // ================================================================
        // Ramp of the command-path level, one step per control cycle
        target = request;
        case (s_q.ramp)
            tmsl_pkg::TMSL_IDLE: begin
                s_d.level = tmsl_pkg::ZERO_HZ;
                if (run_cmd) s_d.ramp = tmsl_pkg::TMSL_ACCEL;  // R1
            end
            tmsl_pkg::TMSL_ACCEL, tmsl_pkg::TMSL_HOLD: begin
                if (!run_cmd) begin
                    s_d.ramp = tmsl_pkg::TMSL_DECEL;  // R2
                end else if (tick) begin
                    if (s_q.level + s_q.acc < target && s_q.level < target)
                        s_d.level = s_q.level + s_q.acc;  // R19
                    else if (s_q.level > target + s_q.dec && target < s_q.level)
                        s_d.level = s_q.level - s_q.dec;  // R19
                    else
                        s_d.level = target;
                    s_d.ramp = (s_d.level == target) ? tmsl_pkg::TMSL_HOLD
                                                     : tmsl_pkg::TMSL_ACCEL;
                end
            end
            tmsl_pkg::TMSL_DECEL: begin
                if (run_cmd) begin
                    s_d.ramp = tmsl_pkg::TMSL_ACCEL;
                end else if (tick) begin
                    if (s_q.level > s_q.dcbrk + s_q.dec)
                        s_d.level = s_q.level - s_q.dec;  // R2 R19
                    else begin
                        s_d.level = tmsl_pkg::ZERO_HZ;
                        s_d.ramp = tmsl_pkg::TMSL_IDLE;
                    end
                end
            end
            default: s_d.ramp = tmsl_pkg::TMSL_IDLE;
        endcase
        // ================================================================
        // Clamp: starting frequency wins over minimum, which wins over maximum
        clamped = s_q.ctrl[0] ? request : s_q.level;  // R3
        if (clamped > s_q.maxf) clamped = s_q.maxf;  // R5
        if (clamped < s_q.minf) clamped = s_q.minf;  // R6
        if ((s_q.ctrl[0] ? request : s_q.level) < s_q.startf) clamped = tmsl_pkg::ZERO_HZ;  // R7
        mag_s = 17'(signed'({1'b0, clamped}));
        if (s_q.ctrl[0] && torque_cmd < 0) s_d.limit = -mag_s;  // R9
        else s_d.limit = mag_s;
        // ================================================================
        // Speed regulation takeover and indication
        s_d.spdreg = (clamped != tmsl_pkg::ZERO_HZ || run_cmd)
                   && (abs_speed >= {1'b0, clamped});  // R17
        s_d.active = s_d.spdreg;  // R11
        s_d.disp = s_d.active ? tmsl_pkg::DISPLAY_LIMIT_CODE : tmsl_pkg::DISPLAY_NONE;  // R11
        if (s_q.codes[7:0] == tmsl_pkg::OUT_FUNC_LIMIT_POS) s_d.lout = s_d.active;  // R12
        else if (s_q.codes[7:0] == tmsl_pkg::OUT_FUNC_LIMIT_NEG) s_d.lout = !s_d.active;
        else s_d.lout = 1'b0;
        // ================================================================
        // Gain set selection
        second_on = second_function_select
                  && (s_q.codes[15:8] == tmsl_pkg::IN_FUNC_SECOND);  // R16
        s_d.pg = (second_on && s_q.pg2 != tmsl_pkg::SETTING_UNUSED) ? s_q.pg2 : s_q.pg1;  // R15
        s_d.it = (second_on && s_q.it2 != tmsl_pkg::SETTING_UNUSED) ? s_q.it2 : s_q.it1;  // R15
        rad_prod = s_d.pg * (s_q.ctrl[2] ? tmsl_pkg::PGAIN_RAD_ENCODER
                                         : tmsl_pkg::PGAIN_RAD_SENSORLESS);  // R13
        s_d.pgrad = 16'(rad_prod / 32'(tmsl_pkg::PCT_FULL));
        // ================================================================
        // Events, sticky status, read clears (set wins)
        s_d.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                tmsl_pkg::REG_CTRL:       s_d.rdata = {29'h0, s_q.ctrl};
                tmsl_pkg::REG_FWD_LIMIT:  s_d.rdata = {16'h0, s_q.fwd};
                tmsl_pkg::REG_REV_LIMIT:  s_d.rdata = {16'h0, s_q.rev};
                tmsl_pkg::REG_MAX_FREQ:   s_d.rdata = {16'h0, s_q.maxf};
                tmsl_pkg::REG_MIN_FREQ:   s_d.rdata = {16'h0, s_q.minf};
                tmsl_pkg::REG_START_FREQ: s_d.rdata = {16'h0, s_q.startf};
                tmsl_pkg::REG_DCBRK_FREQ: s_d.rdata = {16'h0, s_q.dcbrk};
                tmsl_pkg::REG_ACCEL_STEP: s_d.rdata = {16'h0, s_q.acc};
                tmsl_pkg::REG_DECEL_STEP: s_d.rdata = {16'h0, s_q.dec};
                tmsl_pkg::REG_PGAIN1:     s_d.rdata = {16'h0, s_q.pg1};
                tmsl_pkg::REG_ITIME1:     s_d.rdata = {16'h0, s_q.it1};
                tmsl_pkg::REG_PGAIN2:     s_d.rdata = {16'h0, s_q.pg2};
                tmsl_pkg::REG_ITIME2:     s_d.rdata = {16'h0, s_q.it2};
                tmsl_pkg::REG_FUNC_CODES: s_d.rdata = {16'h0, s_q.codes};
                tmsl_pkg::REG_STATUS:     s_d.rdata = {29'h0, s_q.stat};
                tmsl_pkg::REG_MASK:       s_d.rdata = {29'h0, s_q.mask};
                tmsl_pkg::REG_LIMIT:      s_d.rdata = {15'h0, s_q.limit};
                tmsl_pkg::REG_GAINS:      s_d.rdata = {s_q.it, s_q.pg};
                default:                  s_d.rdata = 32'h0000_0000;
            endcase
        end
        if (reg_rd && reg_addr == tmsl_pkg::REG_STATUS) s_d.stat = '0;
        if (s_d.active && !s_q.active) s_d.stat[0] = 1'b1;
        if (!s_d.active && s_q.active) s_d.stat[1] = 1'b1;
        if (s_d.spdreg && !s_q.spdreg) s_d.stat[2] = 1'b1;
        if (reg_wr) begin
            case (reg_addr)
                tmsl_pkg::REG_CTRL:       s_d.ctrl = reg_wdata[2:0];
                tmsl_pkg::REG_FWD_LIMIT:  s_d.fwd = reg_wdata[15:0];
                tmsl_pkg::REG_REV_LIMIT:  s_d.rev = reg_wdata[15:0];
                tmsl_pkg::REG_MAX_FREQ:   s_d.maxf = reg_wdata[15:0];
                tmsl_pkg::REG_MIN_FREQ:   s_d.minf = reg_wdata[15:0];
                tmsl_pkg::REG_START_FREQ: s_d.startf = reg_wdata[15:0];
                tmsl_pkg::REG_DCBRK_FREQ: s_d.dcbrk = reg_wdata[15:0];
                tmsl_pkg::REG_ACCEL_STEP: s_d.acc = reg_wdata[15:0];
                tmsl_pkg::REG_DECEL_STEP: s_d.dec = reg_wdata[15:0];
                // Out-of-range first-set gain and time writes are saturated rather than refused
                tmsl_pkg::REG_PGAIN1:     s_d.pg1 = (reg_wdata[15:0] > tmsl_pkg::PGAIN_MAX_PCT)
                                              ? tmsl_pkg::PGAIN_MAX_PCT : reg_wdata[15:0];  // R13
                tmsl_pkg::REG_ITIME1:     s_d.it1 = (reg_wdata[15:0] > tmsl_pkg::ITIME_MAX_MS)
                                              ? tmsl_pkg::ITIME_MAX_MS : reg_wdata[15:0];  // R14
                tmsl_pkg::REG_PGAIN2:     s_d.pg2 = reg_wdata[15:0];
                tmsl_pkg::REG_ITIME2:     s_d.it2 = reg_wdata[15:0];
                tmsl_pkg::REG_FUNC_CODES: s_d.codes = reg_wdata[15:0];
                tmsl_pkg::REG_MASK:       s_d.mask = reg_wdata[EVTW-1:0];
                default: ;
            endcase
        end
        s_d.irq = |(s_d.stat & s_d.mask);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q        <= '0;
            s_q.fwd    <= tmsl_pkg::FWD_LIMIT_RESET;
            s_q.rev    <= tmsl_pkg::SETTING_UNUSED;
            s_q.maxf   <= tmsl_pkg::MAX_FREQ_RESET;
            s_q.startf <= tmsl_pkg::START_RESET;
            s_q.dcbrk  <= tmsl_pkg::DCBRK_RESET;
            s_q.acc    <= tmsl_pkg::ACCEL_STEP_RESET;
            s_q.dec    <= tmsl_pkg::ACCEL_STEP_RESET;
            s_q.pg1    <= tmsl_pkg::PGAIN_DEFAULT_PCT;  // R13
            s_q.it1    <= tmsl_pkg::ITIME_DEFAULT_MS;   // R14
            s_q.pg2    <= tmsl_pkg::SETTING_UNUSED;
            s_q.it2    <= tmsl_pkg::SETTING_UNUSED;
            s_q.pg     <= tmsl_pkg::PGAIN_DEFAULT_PCT;
            s_q.it     <= tmsl_pkg::ITIME_DEFAULT_MS;
            s_q.pgrad  <= tmsl_pkg::PGAIN_RAD_SENSORLESS;
            s_q.ramp   <= tmsl_pkg::TMSL_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata             = s_q.rdata;
    assign speed_limit           = s_q.limit;
    assign speed_reg_mode        = s_q.spdreg;
    assign limit_active_out      = s_q.lout;
    assign limit_display_code    = s_q.disp;
    assign current_p_gain        = s_q.pg;
    assign current_p_gain_rad    = s_q.pgrad;
    assign current_integral_time = s_q.it;
    assign irq                   = s_q.irq;

    // ====================================================================
    // Checks
    chk_limit_max_clamp: assert property (@(posedge sys_clk) disable iff (rst)
        !s_q.ctrl[0] ##1 1'b1 |-> (s_q.limit <= 17'(signed'({1'b0, $past(s_q.maxf)})))) // R5
        else $error("limit above max frequency");
    chk_zero_below_start: assert property (@(posedge sys_clk) disable iff (rst)
        (!reg_wr && !s_q.ctrl[0] && s_q.level < s_q.startf) |=> (s_q.limit == 17'sh0)) // R7
        else $error("limit not forced to zero");
    chk_torque_sign_neg: assert property (@(posedge sys_clk) disable iff (rst)
        (!reg_wr && s_q.ctrl[0] && torque_cmd < 0) |=> (s_q.limit <= 17'sh0)) // R9
        else $error("limit polarity not negative");
    chk_torque_zero_pos: assert property (@(posedge sys_clk) disable iff (rst)
        (!reg_wr && s_q.ctrl[0] && torque_cmd == 16'sh0) |=> (s_q.limit >= 17'sh0)) // R9
        else $error("zero torque gave negative limit");
    chk_second_fallback: assert property (@(posedge sys_clk) disable iff (rst)
        (!reg_wr && second_function_select && s_q.codes[15:8] == tmsl_pkg::IN_FUNC_SECOND
         && s_q.pg2 == tmsl_pkg::SETTING_UNUSED) |=> (s_q.pg == $past(s_q.pg1))) // R15
        else $error("gain 2 fallback missing");
    chk_second_gate: assert property (@(posedge sys_clk) disable iff (rst)
        (!reg_wr && s_q.codes[15:8] != tmsl_pkg::IN_FUNC_SECOND) |=> (s_q.pg == $past(s_q.pg1))) // R16
        else $error("second set used without code 3");
    chk_out_gate: assert property (@(posedge sys_clk) disable iff (rst)
        (s_q.codes[7:0] != tmsl_pkg::OUT_FUNC_LIMIT_POS
         && s_q.codes[7:0] != tmsl_pkg::OUT_FUNC_LIMIT_NEG) |=> !limit_active_out) // R12
        else $error("limit output without function code");
    chk_display_follow: assert property (@(posedge sys_clk) disable iff (rst)
        s_q.active |-> (limit_display_code == tmsl_pkg::DISPLAY_LIMIT_CODE)) // R11
        else $error("display not showing limit");
    chk_run_start_zero: assert property (@(posedge sys_clk) disable iff (rst)
        (s_q.ramp == tmsl_pkg::TMSL_IDLE && run_cmd)
        |=> (s_q.ramp == tmsl_pkg::TMSL_ACCEL && s_q.level == 16'h0000)) // R1
        else $error("ramp did not start at zero");
    chk_decel_on_stop: assert property (@(posedge sys_clk) disable iff (rst)
        (s_q.ramp == tmsl_pkg::TMSL_HOLD && !run_cmd) |=> (s_q.ramp == tmsl_pkg::TMSL_DECEL)) // R2
        else $error("no decel on run drop");
    cov_accel: cover property (@(posedge sys_clk) s_q.ramp == tmsl_pkg::TMSL_ACCEL);
    cov_decel_idle: cover property (@(posedge sys_clk)
        s_q.ramp == tmsl_pkg::TMSL_DECEL ##1 s_q.ramp == tmsl_pkg::TMSL_IDLE);
    cov_speed_reg: cover property (@(posedge sys_clk) s_q.spdreg);
    cov_irq: cover property (@(posedge sys_clk) irq);
endmodule

// >>> tmsl_motor_model.sv
// Behavioural motor and load at the far side of the limiter.
// Assumes the bench names a load speed; the shaft walks to it or jumps to it.
`timescale 1ns/10ps
module tmsl_motor_model (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic signed [15:0] target_speed,
    input  wire logic               fast,
    output logic signed [15:0]      actual_speed
);
    // ==================================================================
    // Shaft speed
    // Slow mode moves one unit per clock so the limit is crossed gradually
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            actual_speed <= 16'sh0000;
        end else if (fast) begin
            actual_speed <= target_speed;
        end else if (actual_speed < target_speed) begin
            actual_speed <= actual_speed + 16'sh0001;
        end else if (actual_speed > target_speed) begin
            actual_speed <= actual_speed - 16'sh0001;
        end
    end
endmodule

// >>> tmsl_limiter_tb_top.sv
// Self-checking bench for the torque-mode speed limiter.
// Assumes the motor model file is compiled first; reads are scored from a queue.
`timescale 1ns/10ps
module tmsl_limiter_tb_top;
    logic sys_clk, rst, reg_wr, reg_rd, run_cmd, sel2, fast;
    logic [7:0] reg_addr, lim_disp;
    logic [31:0] reg_wdata, reg_rdata;
    logic [15:0] speed_cmd, pg, pgrad, itime, fwd, ms_lim;
    logic [2:0] ms_in;
    logic signed [15:0] torque_cmd, actual_speed, tgt;
    logic signed [16:0] speed_limit, e;
    logic spd_mode, lim_out, irq, pend;
    logic [32:0] exp_q[$];
    int bad_count, check_count, cyc;
    tmsl_limiter tmsl_limiter_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .run_cmd(run_cmd), .speed_cmd(speed_cmd), .multispeed_limit(ms_lim),
        .multispeed_high_in(ms_in[2]), .multispeed_mid_in(ms_in[1]),
        .multispeed_low_in(ms_in[0]), .torque_cmd(torque_cmd), .actual_speed(actual_speed),
        .second_function_select(sel2), .speed_limit(speed_limit), .speed_reg_mode(spd_mode),
        .limit_active_out(lim_out), .limit_display_code(lim_disp), .current_p_gain(pg),
        .current_p_gain_rad(pgrad), .current_integral_time(itime), .irq(irq));
    tmsl_motor_model tmsl_motor_model_i (.sys_clk(sys_clk), .rst(rst),
        .target_speed(tgt), .fast(fast), .actual_speed(actual_speed));
    // ==================================================================
    // Clock, timeout and checking
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic cmp_port(input string n, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic cmp_read(input logic [31:0] x, input logic [31:0] g);
        cmp_port("read data", x, g);
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    // Read data stands only in the cycle after the strobe, so score it mid-cycle
    always @(negedge sys_clk) begin
        if (pend) begin
            if (exp_q[0][32]) cmp_read(exp_q[0][31:0], reg_rdata);
            void'(exp_q.pop_front());
        end
        pend = reg_rd;
    end
    // ==================================================================
    // Register port
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic chk);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back({chk, x});
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask
    // ==================================================================
    // Main sequence
    initial begin
        {rst, reg_wr, reg_rd, run_cmd, sel2, fast, pend} = 7'h40;
        {reg_addr, reg_wdata, speed_cmd, torque_cmd, tgt, ms_in, ms_lim} = '0;
        void'($urandom(32'hB77163AF));
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rd(tmsl_pkg::REG_GAINS, {16'h0005, 16'h0064}, 1'b1);
        cmp_port("p gain rad", 32'h03E8, pgrad);
        wr(tmsl_pkg::REG_PGAIN1, 32'h00C8);
        wr(tmsl_pkg::REG_CTRL, 32'h4);
        cmp_port("p gain rad", 32'h0AF0, pgrad);
        wr(tmsl_pkg::REG_CTRL, 32'h0);
        cmp_port("p gain rad", 32'h07D0, pgrad);
        wr(tmsl_pkg::REG_FUNC_CODES, 32'h0300);
        wr(tmsl_pkg::REG_PGAIN2, 32'h012C);
        wr(tmsl_pkg::REG_ITIME2, 32'h270F);
        sel2 <= 1'b1;
        rd(tmsl_pkg::REG_GAINS, {16'h0005, 16'h012C}, 1'b1);
        cmp_port("p gain", 32'h012C, pg);
        cmp_port("i time", 32'h0005, itime);
        wr(tmsl_pkg::REG_FUNC_CODES, 32'h0000);
        rd(tmsl_pkg::REG_GAINS, {16'h0005, 16'h00C8}, 1'b1);
        rd(8'hF0, 32'h0, 1'b1);
        wr(tmsl_pkg::REG_ACCEL_STEP, 32'h64);
        wr(tmsl_pkg::REG_DECEL_STEP, 32'h64);
        speed_cmd <= 16'h01F4;
        run_cmd <= 1'b1;
        repeat (2600) @(posedge sys_clk);
        cmp_port("early ramp", 32'h0064, speed_limit);
        repeat (15000) @(posedge sys_clk);
        cmp_port("ramp top", 32'h01F4, speed_limit);
        ms_lim <= 16'h0190;
        ms_in <= 3'b001 << ($urandom % 3);
        repeat (2600) @(posedge sys_clk);
        cmp_port("multispeed", 32'h0190, speed_limit);
        ms_in <= 3'b000;
        run_cmd <= 1'b0;
        repeat (20000) @(posedge sys_clk);
        cmp_port("ramp end", 32'h0, speed_limit);
        wr(tmsl_pkg::REG_CTRL, 32'h1);
        for (int i = 0; i < 6; i++) begin
            fwd = (i == 0) ? 16'h1B58 : (i == 1) ? 16'h001E : 16'(100 + $urandom % 5800);
            torque_cmd <= (i == 2) ? 16'sh0000 : ($urandom % 2) ? -16'sd50 : 16'sd50;
            wr(tmsl_pkg::REG_FWD_LIMIT, {16'h0, fwd});
            e = (i == 0) ? 17'sd6000 : (i == 1) ? 17'sd0 : $signed({1'b0, fwd});
            cmp_port("param limit", torque_cmd < 0 ? -e : e, speed_limit);
        end
        wr(tmsl_pkg::REG_MIN_FREQ, 32'h03E8);
        wr(tmsl_pkg::REG_FWD_LIMIT, 32'h01F4);
        cmp_port("min clamp", 32'h03E8, speed_limit < 0 ? -speed_limit : speed_limit);
        wr(tmsl_pkg::REG_MIN_FREQ, 32'h0);
        wr(tmsl_pkg::REG_FWD_LIMIT, 32'h03E8);
        wr(tmsl_pkg::REG_REV_LIMIT, 32'h07D0);
        {torque_cmd, fast, tgt} <= {16'sd100, 1'b1, -16'sd50};
        repeat (4) @(posedge sys_clk);
        cmp_port("reverse", 32'h07D0, speed_limit < 0 ? -speed_limit : speed_limit);
        wr(tmsl_pkg::REG_REV_LIMIT, 32'h270F);
        cmp_port("reverse", 32'h03E8, speed_limit < 0 ? -speed_limit : speed_limit);
        {fast, tgt} <= {1'b0, 16'sd0};
        repeat (60) @(posedge sys_clk);
        rd(tmsl_pkg::REG_STATUS, 32'h0, 1'b0);
        wr(tmsl_pkg::REG_MASK, 32'h1);
        wr(tmsl_pkg::REG_FUNC_CODES, 32'h03);
        tgt <= 16'sd1500;
        for (int k = 0; k < 2000 && irq !== 1'b1; k++) @(posedge sys_clk);
        repeat (2) @(posedge sys_clk);
        cmp_port("irq", 32'h1, irq);
        cmp_port("limit out", 32'h1, lim_out);
        cmp_port("display", 32'hA1, lim_disp);
        cmp_port("speed mode", 32'h1, spd_mode);
        wr(tmsl_pkg::REG_FUNC_CODES, 32'h67);
        cmp_port("limit out", 32'h0, lim_out);
        wr(tmsl_pkg::REG_FUNC_CODES, 32'h05);
        cmp_port("limit out", 32'h0, lim_out);
        rd(tmsl_pkg::REG_STATUS, 32'h5, 1'b1);
        cmp_port("irq", 32'h0, irq);
        wr(tmsl_pkg::REG_MASK, 32'h0);
        tgt <= 16'sd0;
        repeat (1600) @(posedge sys_clk);
        rd(tmsl_pkg::REG_STATUS, 32'h2, 1'b1);
        cmp_port("irq", 32'h0, irq);
        wr(tmsl_pkg::REG_ITIME1, 32'h0258);
        rd(tmsl_pkg::REG_ITIME1, 32'h01F4, 1'b1);
        cmp_port("i time", 32'h01F4, itime);
        tally_and_finish();
    end
endmodule
